// ===== hw/startup_seq_pkg.sv
// Purpose: Constants and types for the post-configuration startup sequencer
// Assumes: Phase selections arrive as static configuration ports
// Notes: Phase codes 0..7 name phases; codes 8 and up are special options
package startup_seq_pkg;

  // ****************************************************************
  // Phase and selection encodings
  // ****************************************************************
  localparam int PHASE_W = 3;
  localparam int SEL_W = 4;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h7;
  localparam logic [SEL_W-1:0] SEL_COMPLETION = 4'h8;
  localparam logic [SEL_W-1:0] SEL_HOLD = 4'h9;
  localparam logic [SEL_W-1:0] SEL_NO_STALL = 4'hf;
  localparam logic [SEL_W-1:0] DEFAULT_DONE_PHASE = 4'h4;
  localparam logic [SEL_W-1:0] DEFAULT_TRISTATE_PHASE = 4'h5;
  localparam logic [SEL_W-1:0] DEFAULT_WRITE_PHASE = 4'h6;
  localparam logic [SEL_W-1:0] DEFAULT_LOCK_PHASE = 4'hf;
  localparam logic [SEL_W-1:0] DEFAULT_MATCH_PHASE = 4'hf;

  // ****************************************************************
  // Startup clock sources
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SRC_CONFIG = 2'b00,
    SRC_USER = 2'b01,
    SRC_SCAN = 2'b10
  } clock_source_t;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_WAIT_PIN = 2'b01,
    ST_WAIT_EDGE = 2'b10,
    ST_COMPLETE = 2'b11
  } seq_state_t;

endpackage

// ===== hw/startup_sequencer.sv
// Purpose: Phase-stepped startup controller run after configuration load
// Assumes: Startup clock edges arrive as clk-synchronous levels on three inputs
// Notes: One phase per rising edge of the selected startup clock
//
// Operation
// - With pipelining on, completion waits for the pin high and then one more startup edge.
// - Completion asserts in a chosen phase 1 to 6 or hold, default 4, later when pipelined.
// - Tri-state release happens in a chosen phase, the completion phase or hold, default 5.
// - Global write enable rises in a chosen phase, the completion phase or hold, default 6.
// - Block RAM access stays blocked until the write-enable phase, which also enables it.
// - A chosen lock-wait phase 0 to 6 stalls until every clock manager is locked.
// - A chosen match-wait phase 0 to 6 stalls until calibration match is reported.
// - The match wait only observes the running calibration result and never starts it.
// - Startup steps on the configuration clock, a user clock or the scan clock.
`timescale 1ns/1ps

module startup_sequencer
  import startup_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire startup_seq_pkg::clock_source_t startup_clock_source_select,
  input wire logic config_clock_source,
  input wire logic user_clock_source,
  input wire logic boundary_scan_clock_source,
  input wire logic completion_pipeline_enable,
  input wire logic [startup_seq_pkg::SEL_W-1:0] done_phase_select,
  input wire logic [startup_seq_pkg::SEL_W-1:0] tristate_release_phase_select,
  input wire logic [startup_seq_pkg::SEL_W-1:0] write_enable_phase_select,
  input wire logic [startup_seq_pkg::SEL_W-1:0] lock_wait_phase_select,
  input wire logic [startup_seq_pkg::SEL_W-1:0] match_wait_phase_select,
  input wire logic clock_managers_locked,
  input wire logic impedance_calibration_matched,
  input wire logic completion_pin,
  output logic completion,
  output logic global_tristate,
  output logic global_write_enable,
  output logic block_ram_enable,
  output logic [startup_seq_pkg::PHASE_W-1:0] phase,
  output logic stalled
);
  import startup_seq_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // True when a selection names the given numbered phase
  function automatic logic sel_hits(input logic [SEL_W-1:0] sel, input logic [PHASE_W-1:0] ph);
    sel_hits = (sel[SEL_W-1] == 1'b0) && (sel[PHASE_W-1:0] == ph);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  seq_state_t state;
  seq_state_t next_state;
  logic [PHASE_W-1:0] next_phase;
  logic next_completion;
  logic next_global_tristate;
  logic next_global_write_enable;
  logic clk_sel;
  logic clk_prev;
  logic next_clk_prev;
  logic step;
  logic lock_stall;
  logic match_stall;
  logic completion_event;
  logic advance;

  // ****************************************************************
  // Startup clock selection and edge detect
  // ****************************************************************
  always_comb
  begin
    unique case (startup_clock_source_select)
      SRC_USER: clk_sel = user_clock_source;
      SRC_SCAN: clk_sel = boundary_scan_clock_source;
      default: clk_sel = config_clock_source;
    endcase
    next_clk_prev = clk_sel;
    step = clk_sel && !clk_prev;
  end

  // ****************************************************************
  // Stall conditions
  // ****************************************************************
  // The match result is only watched here; calibration runs on its own
  always_comb
  begin
    lock_stall = sel_hits(lock_wait_phase_select, phase) && !clock_managers_locked;
    match_stall = sel_hits(match_wait_phase_select, phase)
      && !impedance_calibration_matched;
    // Stalls also apply after completion, since stepping goes on there
    stalled = ((state == ST_RUN) || (state == ST_COMPLETE)) && (lock_stall || match_stall);
  end

  // ****************************************************************
  // Step qualification
  // ****************************************************************
  // The pipelined completion waits freeze the phase; only run and complete step
  always_comb
  begin
    advance = start && step && !stalled
      && ((state == ST_RUN) || (state == ST_COMPLETE));
  end

  // ****************************************************************
  // Phase stepping and global controls
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_completion = completion;
    next_global_tristate = global_tristate;
    next_global_write_enable = global_write_enable;
    completion_event = 1'b0;
    // Phase saturates at the last code so late selections cannot wrap around
    if (advance && (phase != PHASE_LAST))
    begin
      next_phase = phase + 3'h1;
    end
    unique case (state)
      ST_RUN:
      begin
        if (advance)
        begin
          if (sel_hits(done_phase_select, phase))
          begin
            if (completion_pipeline_enable)
            begin
              next_state = ST_WAIT_PIN;
            end
            else
            begin
              completion_event = 1'b1;
              next_state = ST_COMPLETE;
            end
          end
        end
      end
      ST_WAIT_PIN:
      begin
        if (completion_pin)
        begin
          next_state = ST_WAIT_EDGE;
        end
      end
      ST_WAIT_EDGE:
      begin
        if (step)
        begin
          completion_event = 1'b1;
          next_state = ST_COMPLETE;
        end
      end
      ST_COMPLETE:
      begin
        // Phases keep stepping here so later release phases still fire
        next_state = ST_COMPLETE;
      end
    endcase
    if (completion_event)
    begin
      next_completion = 1'b1;
    end
    // Hold codes never match a phase, so the control keeps its value
    if (advance && sel_hits(tristate_release_phase_select, phase))
    begin
      next_global_tristate = 1'b0;
    end
    if (advance && sel_hits(write_enable_phase_select, phase))
    begin
      next_global_write_enable = 1'b1;
    end
    if (completion_event && (tristate_release_phase_select == SEL_COMPLETION))
    begin
      next_global_tristate = 1'b0;
    end
    if (completion_event && (write_enable_phase_select == SEL_COMPLETION))
    begin
      next_global_write_enable = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset leaves the I/O tri-stated with all writes blocked
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_RUN;
      phase <= 3'h0;
      completion <= 1'b0;
      global_tristate <= 1'b1;
      global_write_enable <= 1'b0;
      clk_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      completion <= next_completion;
      global_tristate <= next_global_tristate;
      global_write_enable <= next_global_write_enable;
      clk_prev <= next_clk_prev;
    end
  end

  // ****************************************************************
  // Block RAM gating
  // ****************************************************************
  // Block RAMs follow write enable so neither reads nor writes leak early
  assign block_ram_enable = global_write_enable;

endmodule

// ===== testbench/startup_monitor.sv
// Purpose: Port checker; Assumes: one clk domain; Notes: bound to the sequencer
`timescale 1ns/1ps
module startup_monitor
  import startup_seq_pkg::*;
(
  input wire logic clk, rst, start, completion_pipeline_enable, completion_pin, stalled,
  input wire logic completion, global_tristate, global_write_enable, block_ram_enable,
  input wire logic [SEL_W-1:0] lock_wait_phase_select, match_wait_phase_select,
  input wire logic [PHASE_W-1:0] phase
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_bram_follows_we: assert property (block_ram_enable == global_write_enable)
    else $error("bram enable mismatch");
  a_done_sticky: assert property (completion |=> completion)
    else $error("completion dropped");
  a_we_sticky: assert property (global_write_enable |=> global_write_enable)
    else $error("write enable dropped");
  a_phase_steps_one: assert property ($changed(phase) |-> phase == $past(phase) + 3'h1)
    else $error("phase jumped");
  a_held_phase_frozen: assert property (stalled || !start |=> $stable(phase))
    else $error("phase moved while held");
  a_phase_saturates: assert property (phase == PHASE_LAST |=> phase == PHASE_LAST)
    else $error("phase left last code");
  a_pipe_needs_pin: assert property ($rose(completion) && completion_pipeline_enable
    |-> $past(completion_pin)) else $error("completion before pin");
  a_no_wait_free: assert property (lock_wait_phase_select == SEL_NO_STALL
    && match_wait_phase_select == SEL_NO_STALL |-> !stalled) else $error("stall unasked");
  c_completion: cover property ($rose(completion));
  c_stall: cover property (stalled);
  c_pipe_done: cover property ($rose(completion) && completion_pipeline_enable);
  c_late_release: cover property (completion && $fell(global_tristate));
endmodule
bind startup_sequencer startup_monitor mon_u (.*);

// ===== testbench/config_source_model.sv
// Purpose: Config source model; Assumes: clk-sampled levels; Notes: two clk per level
`timescale 1ns/1ps
module config_source_model
(
  input wire logic clk,
  input wire logic enable,
  input wire logic completion_pin,
  output logic config_clock_source
);
  logic [1:0] div = 2'h0;
  // Keeps clocking until completion, since startup length varies; then stands still low
  always @(posedge clk)
    div <= (enable && !completion_pin) ? div + 2'h1 : 2'h0;
  assign config_clock_source = div[1];
endmodule

// ===== testbench/tb.sv
// Purpose: Directed startup tests; Assumes: edges as levels; Notes: config clock from model
`timescale 1ns/1ps
module tb;
  import startup_seq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, run_src = 1'b0, completion_pin = 1'b0;
  logic user_clock_source = 1'b0, boundary_scan_clock_source = 1'b0;
  logic completion_pipeline_enable = 1'b0, clock_managers_locked = 1'b1;
  logic impedance_calibration_matched = 1'b1;
  clock_source_t startup_clock_source_select = SRC_CONFIG;
  logic [SEL_W-1:0] done_phase_select = 4'h4, tristate_release_phase_select = 4'h5;
  logic [SEL_W-1:0] write_enable_phase_select = 4'h6, lock_wait_phase_select = 4'hf;
  logic [SEL_W-1:0] match_wait_phase_select = 4'hf;
  logic config_clock_source, completion, global_tristate, global_write_enable;
  logic block_ram_enable, stalled;
  logic [PHASE_W-1:0] phase;
  int failures = 0, num_checks = 0;
  always #5 clk = ~clk;
  startup_sequencer dut_u (.*);
  config_source_model src_u (.clk(clk), .enable(run_src), .completion_pin(completion),
    .config_clock_source(config_clock_source));
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp)
      $display("[ERR] %s expected %h got %h", name, exp, got);
    failures += (got !== exp);
  endtask
  task automatic expect_out(input logic [3:0] ph, input logic d, t, w);
    chk("phase", ph, {1'b0, phase});
    chk("completion", {3'h0, d}, {3'h0, completion});
    chk("tristate", {3'h0, t}, {3'h0, global_tristate});
    chk("write_en", {3'h0, w}, {3'h0, global_write_enable});
    chk("bram_en", {3'h0, w}, {3'h0, block_ram_enable});
  endtask
  // Two samples high, two low: the sequencer needs a low sample between edges
  task automatic step(input int n);
    repeat (n)
    begin
      user_clock_source = (startup_clock_source_select == SRC_USER);
      boundary_scan_clock_source = (startup_clock_source_select == SRC_SCAN);
      repeat (2) @(negedge clk);
      {user_clock_source, boundary_scan_clock_source} = 2'b00;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic restart();
    @(negedge clk) rst = 1'b1;
    start = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100us failures++;
    stop_test();
  end
  initial
  begin
    restart();
    run_src = 1'b1;
    repeat (20) @(negedge clk);
    chk("phase", 4'h0, {1'b0, phase});
    start = 1'b1;
    for (int i = 0; i < 300 && completion !== 1'b1; i++) @(negedge clk);
    expect_out(4'h5, 1'b1, 1'b1, 1'b0);
    $display("test 1 done");
    run_src = 1'b0;
    startup_clock_source_select = SRC_USER;
    {done_phase_select, tristate_release_phase_select} = 8'h62;
    {write_enable_phase_select, lock_wait_phase_select} = 8'h83;
    clock_managers_locked = 1'b0;
    restart();
    start = 1'b1;
    step(6);
    expect_out(4'h3, 1'b0, 1'b0, 1'b0);
    chk("stalled", 4'h1, {3'h0, stalled});
    clock_managers_locked = 1'b1;
    step(3);
    expect_out(4'h6, 1'b0, 1'b0, 1'b0);
    step(1);
    expect_out(4'h7, 1'b1, 1'b0, 1'b1);
    $display("test 2 done");
    startup_clock_source_select = SRC_SCAN;
    {done_phase_select, tristate_release_phase_select} = 8'h19;
    {write_enable_phase_select, lock_wait_phase_select, match_wait_phase_select} = 12'h0f1;
    {completion_pipeline_enable, impedance_calibration_matched} = 2'b10;
    restart();
    start = 1'b1;
    step(3);
    expect_out(4'h1, 1'b0, 1'b1, 1'b1);
    impedance_calibration_matched = 1'b1;
    step(3);
    chk("completion", 4'h0, {3'h0, completion});
    completion_pin = 1'b1;
    repeat (3) @(negedge clk);
    chk("completion", 4'h0, {3'h0, completion});
    step(1);
    chk("completion", 4'h1, {3'h0, completion});
    chk("tristate", 4'h1, {3'h0, global_tristate});
    step(1);
    chk("phase", 4'h3, {1'b0, phase});
    $display("test 3 done");
    startup_clock_source_select = SRC_USER;
    {done_phase_select, tristate_release_phase_select} = 8'h45;
    {write_enable_phase_select, lock_wait_phase_select, match_wait_phase_select} = 12'h6ff;
    completion_pipeline_enable = 1'b0;
    completion_pin = 1'b0;
    restart();
    start = 1'b1;
    step(5);
    expect_out(4'h5, 1'b1, 1'b1, 1'b0);
    step(1);
    expect_out(4'h6, 1'b1, 1'b0, 1'b0);
    step(2);
    expect_out(4'h7, 1'b1, 1'b0, 1'b1);
    $display("test 4 done");
    stop_test();
  end
endmodule
